// *** logic/rco_pkg.sv ***
// constants, types and helpers for the reference clock output block
//------------------------------------------------------------
// Behaviour
// R1 - source code 0..4 picks system, high, low, mid, secondary oscillator
// R2 - after enable the output starts on a source rising edge, no runt
// R3 - clearing enable forces the output low at once
// R4 - selected source divided by 1, 2, 4 ... 128
// R5 - divider and duty writes take effect while running
// R6 - software should change the divider only while disabled; here divider writes are accepted and act while running
// R7 - software should change the duty only while disabled; here duty writes are accepted and act while running
// R8 - divided output high for 0, 25, 50 or 75 percent of period
// R9 - undivided output is 50 percent for nonzero duty, low for zero
// R10 - duty field resets to binary 10
// R11 - keeps running in sleep unless the system oscillator is selected
// R12 - output drives the pin and an internal peripheral signal
// R13 - divider code n divides by two to the power n
// R14 - duty field sits in control bits 4:3
// R15 - control bit 7 is the enable, reset to zero
// R16 - while disabled output low and counters held at start
// R17 - source select changes act on the next source edge; here a level mismatch after the switch counts as an edge at once
//------------------------------------------------------------
package rco_pkg;

	localparam logic [11:0] CTRL_OFFSET = 12'hF3E;
	localparam logic [11:0] SRC_OFFSET = 12'hF3F;

	localparam int EN_BIT = 7;
	localparam int DUTY_HI = 4;
	localparam int DUTY_LO = 3;
	localparam int DIV_HI = 2;
	localparam int DIV_LO = 0;
	localparam int SRC_HI = 2;

	localparam logic CTRL_EN_RESET = 1'b0;
	localparam logic [1:0] CTRL_DUTY_RESET = 2'h2;
	localparam logic [2:0] CTRL_DIV_RESET = 3'h0;
	localparam logic [2:0] SRC_RESET = 3'h0;

	localparam logic [2:0] SRC_SYS = 3'h0;
	localparam logic [2:0] SRC_HFI = 3'h1;
	localparam logic [2:0] SRC_LFI = 3'h2;
	localparam logic [2:0] SRC_MFI = 3'h3;
	localparam logic [2:0] SRC_SEC = 3'h4;

	typedef struct packed {
		logic en;
		logic [1:0] duty;
		logic [2:0] div;
	} rco_ctrl_t;

	typedef enum {
		RCO_IDLE,
		RCO_ARM,
		RCO_RUN
	} rco_state_t;

	// last half-cycle index of one output period
	function automatic logic [7:0] rco_half_mask(input logic [2:0] div);
		logic [8:0] t;
		t = 9'h002 << div;
		t = t - 9'h001;
		return t[7:0];
	endfunction

	// number of source half-cycles the output stays high
	function automatic logic [8:0] rco_high_halves(input logic [1:0] duty,
		input logic [2:0] div);
		logic [8:0] t;
		t = {7'h00, duty} << div;
		if (div == 3'h0) begin
			t = (duty != 2'h0) ? 9'h001 : 9'h000;
		end else begin
			t = t >> 1;
		end
		return t;
	endfunction

endpackage

// *** logic/rco_top.sv ***
// reference clock output generator with its register port
module rco_top
	import rco_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [11:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic SLEEP,
	input wire logic SYS_OSC,
	input wire logic HIGH_FREQ_INTERNAL_OSC,
	input wire logic LOW_FREQ_INTERNAL_OSC,
	input wire logic MID_FREQ_INTERNAL_OSC,
	input wire logic SECONDARY_OSC,
	output logic REF_CLK_OUT,
	output logic REF_CLK_INT
);

	//------------------------------------------------------------
	// register port
	//------------------------------------------------------------
	rco_ctrl_t ctrl;
	rco_ctrl_t next_ctrl;
	logic [2:0] src_code;
	logic [7:0] next_rdata;
	wire wr_ctrl = WR && (ADDR == CTRL_OFFSET);
	wire wr_src = WR && (ADDR == SRC_OFFSET);
	wire rd_ctrl = RD && (ADDR == CTRL_OFFSET);
	wire rd_src = RD && (ADDR == SRC_OFFSET);
	wire [7:0] ctrl_byte = {ctrl.en, 2'h0, ctrl.duty, ctrl.div};

	// R5 R14 R15 - live field writes accepted
	assign next_ctrl = wr_ctrl ?
		'{en: WDATA[EN_BIT], duty: WDATA[DUTY_HI:DUTY_LO],
		div: WDATA[DIV_HI:DIV_LO]} : ctrl;
	// unmapped addresses read as zero
	assign next_rdata = rd_ctrl ? ctrl_byte :
		rd_src ? {5'h00, src_code} : 8'h00;

	// R10 - reset values of control and select
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl <= '{en: CTRL_EN_RESET, duty: CTRL_DUTY_RESET,
				div: CTRL_DIV_RESET};
			src_code <= SRC_RESET;
			RDATA <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			if (wr_src) begin
				src_code <= WDATA[SRC_HI:0];
			end
			RDATA <= next_rdata;
		end
	end

	//------------------------------------------------------------
	// source selection and edge detection
	//------------------------------------------------------------
	logic src_prev;
	// R1 R17 - reserved codes select a quiet low source
	wire src_sel = (src_code == SRC_SYS) ? SYS_OSC :
		(src_code == SRC_HFI) ? HIGH_FREQ_INTERNAL_OSC :
		(src_code == SRC_LFI) ? LOW_FREQ_INTERNAL_OSC :
		(src_code == SRC_MFI) ? MID_FREQ_INTERNAL_OSC :
		(src_code == SRC_SEC) ? SECONDARY_OSC : 1'b0;
	// R11 - system oscillator stops in sleep, so nothing advances
	wire freeze = SLEEP && (src_code == SRC_SYS);
	// a select change shows as an edge here at once if the new source level differs from the old
	wire src_edge = (src_sel != src_prev) && !freeze;
	wire src_rise = src_edge && src_sel;

	//------------------------------------------------------------
	// enable sequencing and divider
	//------------------------------------------------------------
	rco_state_t state;
	rco_state_t next_state;
	logic [7:0] hc;
	logic [7:0] next_hc;
	logic next_out;
	wire [7:0] mask = rco_half_mask(ctrl.div);
	// R8 R9 R13 - high time and period follow the live fields
	wire [8:0] thr = rco_high_halves(next_ctrl.duty, next_ctrl.div);
	wire [7:0] hc_step = (hc + 8'h01) & rco_half_mask(next_ctrl.div);
	// a live divider cut must not leave the count beyond the new period
	wire [7:0] hc_held = hc & rco_half_mask(next_ctrl.div);

	always_comb begin
		next_state = state;
		next_hc = hc;
		next_out = REF_CLK_OUT;
		case (state)
			RCO_IDLE: begin
				next_hc = 8'h00;
				next_out = 1'b0;
				if (next_ctrl.en) begin
					next_state = RCO_ARM;
				end
			end
			RCO_ARM: begin
				next_hc = 8'h00;
				next_out = 1'b0;
				// R2 - wait for a rising source edge before the first pulse
				if (src_rise) begin
					next_state = RCO_RUN;
					next_out = (thr != 9'h000);
				end
			end
			RCO_RUN: begin
				// R4 R5 - divide and shape by counting source half-cycles
				next_hc = src_edge ? hc_step : hc_held;
				next_out = ({1'b0, next_hc} < thr);
			end
			default: begin
				next_state = RCO_IDLE;
				next_hc = 8'h00;
				next_out = 1'b0;
			end
		endcase
		// R3 R16 - disable stops the output at once and resets the counters
		if (!next_ctrl.en) begin
			next_state = RCO_IDLE;
			next_hc = 8'h00;
			next_out = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= RCO_IDLE;
			hc <= 8'h00;
			src_prev <= 1'b0;
			REF_CLK_OUT <= 1'b0;
			REF_CLK_INT <= 1'b0;
		end else begin
			state <= next_state;
			hc <= next_hc;
			src_prev <= freeze ? src_prev : src_sel;
			REF_CLK_OUT <= next_out;
			// R12 - same waveform for the on-chip consumers
			REF_CLK_INT <= next_out;
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_live_run;
		state == RCO_RUN && $past(state) == RCO_RUN;
	endsequence
	sequence s_undiv_steady;
		ctrl.div == 3'h0 && ctrl.duty != 2'h0 &&
		$stable(ctrl) && !$past(freeze);
	endsequence

	chk_disable_low: assert property ($fell(ctrl.en) |-> !REF_CLK_OUT) // R3
		else $error("output not low after disable");
	chk_idle_held: assert property (!ctrl.en |-> hc == 8'h00 && !REF_CLK_OUT) // R16
		else $error("counters not held while disabled");
	chk_arm_clean: assert property (state == RCO_ARM |-> !REF_CLK_OUT) // R2
		else $error("output moved before first source edge");
	chk_start_edge: assert property ($rose(state == RCO_RUN) |-> $past(src_rise)) // R2
		else $error("start not on a rising source edge");
	chk_hc_wrap: assert property (state == RCO_RUN |-> hc <= mask) // R4
		else $error("half-cycle count beyond period");
	chk_zero_duty: assert property (s_live_run and ##0 (ctrl.duty == 2'h0 &&
		$stable(ctrl)) |-> !REF_CLK_OUT) // R8
		else $error("zero duty output went high");
	chk_undiv_follow: assert property (s_live_run and s_undiv_steady |->
		REF_CLK_OUT == $past(src_sel)) // R9
		else $error("undivided output does not follow source");
	chk_sleep_hold: assert property (freeze && state == RCO_RUN && !WR |=>
		$stable(REF_CLK_OUT)) // R11
		else $error("output moved in sleep on system source");
	chk_ctrl_write: assert property (wr_ctrl |=> ctrl_byte ==
		($past(WDATA) & 8'h9F)) // R5
		else $error("control write lost");
	chk_read_data: assert property (rd_ctrl |=> RDATA == $past(ctrl_byte)) // R14
		else $error("control read wrong");
	chk_src_map: assert property (src_code == SRC_MFI |->
		src_sel == MID_FREQ_INTERNAL_OSC) // R1
		else $error("source select wrong");
	chk_int_route: assert property (REF_CLK_INT == REF_CLK_OUT) // R12
		else $error("internal clock differs from pin");

endmodule

// *** verif/rco_osc_model.sv ***
// free-running sources; each level lasts k+2 cycles so CLK can see it
module rco_osc_model (
	input wire logic clk,
	output logic [4:0] osc = 5'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt [5] = '{default: 0};
	always @(posedge clk) begin
		for (int k = 0; k < 5; k++) begin
			cnt[k] <= (cnt[k] == k + 1) ? 0 : cnt[k] + 1;
			if (cnt[k] == k + 1) osc[k] <= ~osc[k];
		end
	end
endmodule

// *** verif/rco_tb_top.sv ***
// self-checking bench for the reference clock output block
module rco_tb_top
	import rco_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, wr, rd, sleep, ref_out, ref_int;
	logic [11:0] addr;
	logic [7:0] wdata, rdata;
	logic [4:0] osc;
	int miscompares = 0;
	int tests_run = 0;
	int hi, lo, n;
	rco_osc_model rco_osc_model_i (.clk(clk), .osc(osc));
	rco_top rco_top_i (.CLK(clk), .RESETN(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SLEEP(sleep),
		.SYS_OSC(osc[0]), .HIGH_FREQ_INTERNAL_OSC(osc[1]),
		.LOW_FREQ_INTERNAL_OSC(osc[2]), .MID_FREQ_INTERNAL_OSC(osc[3]),
		.SECONDARY_OSC(osc[4]), .REF_CLK_OUT(ref_out), .REF_CLK_INT(ref_int));
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input int got, input int exp);
		tests_run++;
		if (got != exp) begin
			miscompares++;
			$display("CHECK FAILED %0t count %0d not %0d", $time, got, exp);
		end
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t value %h not %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic bus_rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp8(rdata, exp);
	endtask
	// measures the first whole pulse, so a runt would shorten hi
	task automatic meas();
		int i;
		hi = 0;
		lo = 0;
		for (i = 0; i < 4000 && ref_out !== 1'b0; i++) @(negedge clk);
		for (i = 0; i < 4000 && ref_out !== 1'b1; i++) @(negedge clk);
		while (hi < 4000 && ref_out === 1'b1) begin
			hi++;
			@(negedge clk);
		end
		while (lo < 4000 && ref_out === 1'b0) begin
			lo++;
			@(negedge clk);
		end
	endtask
	task automatic stuck();
		logic v;
		n = 0;
		v = ref_out;
		repeat (600) begin
			@(negedge clk);
			if (ref_out !== v) n++;
			v = ref_out;
		end
	endtask
	task automatic run(input int d, input int c, input int h);
		bus_wr(CTRL_OFFSET, {3'h0, c[1:0], d[2:0]});
		cmp8({7'h00, ref_out}, 8'h00);
		bus_wr(CTRL_OFFSET, {3'h4, c[1:0], d[2:0]});
		meas();
		cmp(hi, (d == 0) ? h : ((c << d) >> 1) * h);
		cmp(hi + lo, (2 << d) * h);
		cmp8({7'h00, ref_int}, {7'h00, ref_out});
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#2000000;
		miscompares++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		sleep = 1'b0;
		addr = 12'h000;
		wdata = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		bus_rd(CTRL_OFFSET, 8'h10);
		bus_rd(SRC_OFFSET, 8'h00);
		bus_rd(12'hF40, 8'h00);
		bus_wr(CTRL_OFFSET, 8'h7F);
		bus_rd(CTRL_OFFSET, 8'h1F);
		bus_wr(SRC_OFFSET, 8'hFC);
		bus_rd(SRC_OFFSET, 8'h04);
		for (int s = 0; s < 5; s++) begin
			bus_wr(SRC_OFFSET, s[7:0]);
			run(1, 2, s + 2);
		end
		bus_wr(SRC_OFFSET, 8'h00);
		for (int d = 0; d < 8; d++) begin
			for (int c = 1; c < 4; c++) run(d, c, 2);
		end
		bus_wr(CTRL_OFFSET, 8'h92);
		meas();
		meas();
		cmp(hi, 8);
		cmp(hi + lo, 16);
		for (int v = 8'h80; v < 8'h84; v += 3) begin
			bus_wr(CTRL_OFFSET, 8'h00);
			bus_wr(CTRL_OFFSET, v[7:0]);
			stuck();
			cmp(n, 0);
			cmp8({7'h00, ref_out}, 8'h00);
		end
		bus_wr(SRC_OFFSET, 8'h05);
		bus_wr(CTRL_OFFSET, 8'h92);
		stuck();
		cmp(n, 0);
		bus_wr(SRC_OFFSET, 8'h00);
		sleep <= 1'b1;
		stuck();
		cmp(n, 0);
		bus_wr(SRC_OFFSET, 8'h02);
		run(1, 2, 4);
		results();
	end
endmodule
